// >>> pgc_pkg.sv
// Package for the page granularity control register block
package pgc_pkg;
    localparam int          PGC_BIT_LPA_EN   = 29;
    localparam int          PGC_BIT_SP_EN    = 28;
    localparam logic [31:0] PGC_RESET_VALUE  = 32'h0000_0000;
    localparam logic [1:0]  PGC_PAGE_MASK_EXT_FORCED = 2'h3;
    localparam logic [1:0]  PGC_PAGE_MASK_EXT_RESET  = 2'h0;
endpackage : pgc_pkg

// >>> pgc_wr_if.sv
// Interface carrying one coprocessor register write from the core
`timescale 1ns/1ps
`default_nettype none
interface pgc_wr_if;
    logic        we;
    logic [31:0] wdata;
    modport src (output we, output wdata);
    modport dst (input we, input wdata);
endinterface : pgc_wr_if
`default_nettype wire

// >>> pgc_mask_ext.sv
// Page mask extension field holder, gated by small page mode
`timescale 1ns/1ps
`default_nettype none
module pgc_mask_ext (
    input  wire logic       clk_i,
    input  wire logic       rst_b_i,
    input  wire logic       sp_on_i,
    pgc_wr_if.dst           wr,
    output logic      [1:0] rd_o,
    output logic      [1:0] tlb_o
);
    import pgc_pkg::*;
    logic [1:0] page_mask_ext_r;
    logic [1:0] page_mask_ext_nxt;

    // Field only accepts writes while small pages are on
    assign page_mask_ext_nxt = (wr.we && sp_on_i) ? wr.wdata[12:11] : page_mask_ext_r;

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            page_mask_ext_r <= PGC_PAGE_MASK_EXT_RESET;
        end else begin
            page_mask_ext_r <= page_mask_ext_nxt;
        end
    end

    // Reads zero and the TLB sees 0b11 when disabled
    assign rd_o  = sp_on_i ? page_mask_ext_r : 2'h0;
    assign tlb_o = sp_on_i ? page_mask_ext_r : PGC_PAGE_MASK_EXT_FORCED;
endmodule : pgc_mask_ext
`default_nettype wire

// >>> pgc_page_granularity_control.sv
// Page granularity control register and the translation field shaping it steers
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - With large-address enable (bit 29) set, frame number extension of both low entries is writable and joined above the frame number.
// - Without large-address capability, the large-address enable ignores writes and reads zero.
// - With small-page enable (bit 28) set, frame numbers hold the physical address down to bit 10, shifted left two places.
// - With small pages on, the page mask extension is writable and joined with the page mask.
// - With small pages on, the virtual page pair extension joins the match number; VA bits 12 and 11 have no effect on it.
// - With small pages off, the mask extension rejects writes, reads zero and acts as 0b11 on TLB writes.
// - Bits 27 to 13 and 7 to 0 always read zero.
// - Vendor extension positions 31 to 30 and 12 to 8 read zero and have no effect here.
// - With the vendor extension present, neither enable exists.
//
// Control word layout:
//   31:30  vendor extension positions, read zero, no effect
//   29     large-address enable
//   28     small-page enable
//   27:13  reserved, read zero
//   12:8   vendor extension positions, read zero, no effect
//   7:0    reserved, read zero
// Timing:
//   a write is taken on the rising edge that sees the strobe high
//   the enables show one cycle later
//   the read word and the shaped translation fields show two cycles later
// Limitations:
//   the clearing sequence that software owes before a change is not checked here;
//   a change without it leaves stale frames in flight for one cycle
//   losing a capability clears its enable on the next edge without a write
// Outputs:
//   every output leaves straight from a flip-flop, so the TLB side sees no glitches
module pgc_page_granularity_control (
    input  wire logic        clk_i,
    input  wire logic        rst_b_i,
    input  wire logic        large_addr_capable_i,
    input  wire logic        small_page_capable_i,
    input  wire logic        vendor_ext_present_i,
    input  wire logic        pgc_we_i,
    input  wire logic [31:0] pgc_wdata_i,
    input  wire logic        mask_we_i,
    input  wire logic [31:0] mask_wdata_i,
    input  wire logic [31:0] pfn_even_i,
    input  wire logic [31:0] pfn_odd_i,
    input  wire logic [31:0] frame_number_ext_even_i,
    input  wire logic [31:0] frame_number_ext_odd_i,
    input  wire logic [26:0] virt_page_pair_number_i,
    input  wire logic [1:0]  virt_page_pair_ext_i,
    input  wire logic [1:0]  va_low_i,
    input  wire logic [15:0] mask_i,
    output logic      [31:0] pgc_rdata_o,
    output logic             large_phys_addr_enable_o,
    output logic             small_page_enable_o,
    output logic      [1:0]  page_mask_ext_o,
    output logic      [17:0] tlb_mask_o,
    output logic      [63:0] frame_even_o,
    output logic      [63:0] frame_odd_o,
    output logic      [28:0] match_vpn_o
);
    import pgc_pkg::*;

    // Architectural state: the two enables
    logic        lpa_r;
    logic        sp_r;
    logic        lpa_nxt;
    logic        sp_nxt;

    // Write decode
    logic        lpa_ok;
    logic        sp_ok;
    logic        lpa_wbit;
    logic        sp_wbit;

    // Read path
    logic [31:0] rd_word;
    logic [31:0] rdata_r;
    logic [1:0]  mx_rd;
    logic [1:0]  mx_rd_r;

    // Mask extension toward the TLB
    logic [1:0]  mx_tlb;
    logic [17:0] tmask_nxt;
    logic [17:0] tmask_r;

    // Frame shaping, one slot per low entry (0 even, 1 odd)
    logic [31:0] pfn_sel   [2];
    logic [31:0] frame_number_ext_sel  [2];
    logic [63:0] frame_nxt [2];
    logic [63:0] fe_nxt;
    logic [63:0] fo_nxt;
    logic [63:0] fe_r;
    logic [63:0] fo_r;

    // Match number
    logic [1:0]  vpn_low;
    logic [28:0] vpn_nxt;
    logic [28:0] vpn_r;

    // Mask writes travel to the holder on the shared write carrier
    pgc_wr_if mwr ();
    assign mwr.we    = mask_we_i;
    assign mwr.wdata = mask_wdata_i;

    // Enables exist only when capable and no vendor extension overrides them
    assign lpa_ok   = large_addr_capable_i && !vendor_ext_present_i;
    assign sp_ok    = small_page_capable_i && !vendor_ext_present_i;
    assign lpa_wbit = pgc_wdata_i[PGC_BIT_LPA_EN];
    assign sp_wbit  = pgc_wdata_i[PGC_BIT_SP_EN];

    // Losing capability clears an enable too, so no feature outlives its hardware
    assign lpa_nxt = !lpa_ok ? 1'b0 : (pgc_we_i ? lpa_wbit : lpa_r);
    assign sp_nxt  = !sp_ok ? 1'b0 : (pgc_we_i ? sp_wbit : sp_r);

    // Reset clears both features so translation starts in the legacy layout
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            lpa_r <= PGC_RESET_VALUE[PGC_BIT_LPA_EN];
            sp_r  <= PGC_RESET_VALUE[PGC_BIT_SP_EN];
        end else begin
            lpa_r <= lpa_nxt;
            sp_r  <= sp_nxt;
        end
    end

    // Only the two enables are ever visible; everything else reads zero
    always_comb begin
        rd_word = 32'h0000_0000;
        rd_word[PGC_BIT_LPA_EN] = lpa_r;
        rd_word[PGC_BIT_SP_EN]  = sp_r;
    end

    // Mask extension holder, writable only while small pages are on
    pgc_mask_ext u_mask_ext (
        .clk_i   (clk_i),
        .rst_b_i (rst_b_i),
        .sp_on_i (sp_r),
        .wr      (mwr),
        .rd_o    (mx_rd),
        .tlb_o   (mx_tlb)
    );

    // Gather each entry's fields so one loop shapes both
    assign pfn_sel[0]  = pfn_even_i;
    assign pfn_sel[1]  = pfn_odd_i;
    assign frame_number_ext_sel[0] = frame_number_ext_even_i;
    assign frame_number_ext_sel[1] = frame_number_ext_odd_i;

    // Per-entry frame shaping
    for (genvar e = 0; e < 2; e++) begin : g_entry
        logic [31:0] ext_part;
        logic [63:0] joined;
        // Extension joins above the frame number only in large-address mode
        assign ext_part     = lpa_r ? frame_number_ext_sel[e] : 32'h0000_0000;
        assign joined       = {ext_part, pfn_sel[e]};
        // Small pages reach PA bit 10; the top two extension bits fall off
        assign frame_nxt[e] = sp_r ? {joined[61:0], 2'h0} : joined;
    end

    // Slot 0 feeds the even entry, slot 1 the odd one
    assign fe_nxt = frame_nxt[0];
    assign fo_nxt = frame_nxt[1];

    // The extension already spans every VA 12:11 pattern, so the VA bits
    // cannot narrow the match further; with small pages off both bits are zero
    assign vpn_low = sp_r ? ((virt_page_pair_ext_i & va_low_i) | virt_page_pair_ext_i) : 2'h0;
    assign vpn_nxt = {virt_page_pair_number_i, vpn_low};

    // Page mask seen by a TLB write: forced 0b11 below it while small pages are off
    assign tmask_nxt = {mask_i, mx_tlb};

    // Read path registers; one cycle behind the enables, fine since software
    // must settle translation state before relying on a change
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rdata_r <= 32'h0000_0000;
            mx_rd_r <= 2'h0;
        end else begin
            rdata_r <= rd_word;
            mx_rd_r <= mx_rd;
        end
    end

    // TLB mask register
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            tmask_r <= 18'h0_0000;
        end else begin
            tmask_r <= tmask_nxt;
        end
    end

    // Frame registers for both low entries
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            fe_r <= 64'h0;
            fo_r <= 64'h0;
        end else begin
            fe_r <= fe_nxt;
            fo_r <= fo_nxt;
        end
    end

    // Match number register
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            vpn_r <= 29'h0;
        end else begin
            vpn_r <= vpn_nxt;
        end
    end

    // Every output comes straight from a register
    assign pgc_rdata_o              = rdata_r;
    assign large_phys_addr_enable_o = lpa_r;
    assign small_page_enable_o      = sp_r;
    assign page_mask_ext_o          = mx_rd_r;
    assign tlb_mask_o               = tmask_r;
    assign frame_even_o             = fe_r;
    assign frame_odd_o              = fo_r;
    assign match_vpn_o              = vpn_r;
endmodule : pgc_page_granularity_control
`default_nettype wire

// >>> pgc_checker.sv
// Port checker for the page granularity control register
`timescale 1ns/1ps
`default_nettype none
module pgc_chk (
    input wire logic        clk_i, rst_b_i, large_addr_capable_i, small_page_capable_i,
    input wire logic        vendor_ext_present_i, pgc_we_i, large_phys_addr_enable_o,
    input wire logic        small_page_enable_o,
    input wire logic [31:0] pgc_wdata_i, pgc_rdata_o,
    input wire logic [1:0]  page_mask_ext_o,
    input wire logic [17:0] tlb_mask_o
);
    import pgc_pkg::*;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);
    // Writes that may land, and a settled small-page-off stretch
    wire logic ok_w = pgc_we_i && !vendor_ext_present_i;
    sequence lw_s; ok_w && pgc_wdata_i[PGC_BIT_LPA_EN] && large_addr_capable_i; endsequence
    sequence sw_s; ok_w && pgc_wdata_i[PGC_BIT_SP_EN] && small_page_capable_i; endsequence
    sequence off_s; !small_page_enable_o [*3]; endsequence
    lpa_on_a: assert property (lw_s |=> large_phys_addr_enable_o) else $error("lpa unset");
    sp_on_a: assert property (sw_s |=> small_page_enable_o) else $error("sp unset");
    sp_cap_a: assert property (!small_page_capable_i |=> !small_page_enable_o)
        else $error("sp without capability");
    vend_off_a: assert property (vendor_ext_present_i |=> !large_phys_addr_enable_o
        && !small_page_enable_o) else $error("enable with vendor ext");
    rsvd_zero_a: assert property ({pgc_rdata_o[31:30], pgc_rdata_o[27:0]} == 30'h0)
        else $error("reserved bits set");
    rd_lag_a: assert property (pgc_rdata_o[29:28] == $past({large_phys_addr_enable_o,
        small_page_enable_o})) else $error("read value lags wrong");
    mask_off_a: assert property (off_s |-> tlb_mask_o[1:0] == PGC_PAGE_MASK_EXT_FORCED
        && page_mask_ext_o == 2'h0) else $error("mask ext not forced");
    rst_clr_a: assert property ($rose(rst_b_i) |-> !large_phys_addr_enable_o
        && !small_page_enable_o) else $error("enable after reset");
endmodule : pgc_chk
bind pgc_page_granularity_control pgc_chk chk (.*);
`default_nettype wire

// >>> pgc_core_mdl.sv
// Core model holding the translation fields the register reshapes
`timescale 1ns/1ps
`default_nettype none
module pgc_core_mdl (
    input  wire logic        prep_i,
    output logic      [31:0] pfn_o,
    output logic      [31:0] frame_number_ext_o,
    output logic      [26:0] virt_page_pair_number_o,
    output logic      [1:0]  virt_page_pair_ext_o
);
    // Frame fields and the pair extension read zero while a mode change is prepared, so no stale frame survives it
    assign pfn_o   = prep_i ? 32'h0 : 32'h0123_4567;
    assign frame_number_ext_o  = prep_i ? 32'h0 : 32'h0000_00a5;
    assign virt_page_pair_number_o  = 27'h2ab_cdef;
    assign virt_page_pair_ext_o = prep_i ? 2'h0 : 2'h2;
endmodule : pgc_core_mdl
`default_nettype wire

// >>> testbench.sv
// Self-checking bench for the page granularity control register
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import pgc_pkg::*;
    logic clk_i = 0, rst_b_i = 0, lc = 0, sc = 0, ve = 0, we = 0, mw = 0, pr = 1, le, se;
    logic [31:0] wd = 32'h0, pf, px, rd;
    logic [26:0] v2;
    logic [1:0]  vx, pm;
    logic [17:0] tm;
    logic [63:0] fe, fo;
    logic [28:0] mv;
    int miscompares = 0, comparisons = 0, cyc = 0;
    always #50 clk_i = ~clk_i;
    pgc_core_mdl core (.prep_i(pr), .pfn_o(pf), .frame_number_ext_o(px), .virt_page_pair_number_o(v2), .virt_page_pair_ext_o(vx));
    pgc_page_granularity_control uut (.clk_i, .rst_b_i, .large_addr_capable_i(lc),
        .small_page_capable_i(sc), .vendor_ext_present_i(ve), .pgc_we_i(we), .pgc_wdata_i(wd),
        .mask_we_i(mw), .mask_wdata_i(wd), .pfn_even_i(pf), .pfn_odd_i(px), .frame_number_ext_even_i(px),
        .frame_number_ext_odd_i(pf), .virt_page_pair_number_i(v2), .virt_page_pair_ext_i(vx), .va_low_i(2'h2), .mask_i(16'h00ff),
        .pgc_rdata_o(rd), .large_phys_addr_enable_o(le), .small_page_enable_o(se),
        .page_mask_ext_o(pm), .tlb_mask_o(tm), .frame_even_o(fe), .frame_odd_o(fo),
        .match_vpn_o(mv));
    task chk(input logic [63:0] got, input logic [63:0] exp);
        comparisons++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    // One write pulse, then wait out the two-cycle read path; the idle gap
    // stands in for the hazard barrier software owes after a write
    task wr(input logic m, input logic [31:0] d);
        @(posedge clk_i);
        {mw, we, wd} <= {m, !m, d};
        @(posedge clk_i);
        {mw, we} <= 2'h0;
        repeat (3) @(posedge clk_i);
        #1;
    endtask : wr
    task caps(input logic l, s, v, p);
        @(posedge clk_i);
        {lc, sc, ve, pr} <= {l, s, v, p};
    endtask : caps
    task t_rst;
        chk({rd, le, se}, 34'h0);
        $display("reset test done");
    endtask : t_rst
    task t_on;
        caps(1, 1, 0, 1);
        wr(0, 32'hffff_ffff);
        chk(rd, 32'h3000_0000);
        caps(1, 1, 0, 0);
        wr(1, 32'h0000_0800);
        chk(fe, {px, pf} << 2);
        chk(fo, {pf, px} << 2);
        chk(mv, {v2, vx});
        chk({pm, tm}, {2'h1, 16'h00ff, 2'h1});
        $display("enable test done");
    endtask : t_on
    task t_off;
        caps(0, 0, 0, 1);
        wr(0, 32'hffff_ffff);
        wr(1, 32'h0000_0800);
        chk({rd, pm, tm}, {32'h0, 2'h0, 16'h00ff, 2'h3});
        caps(0, 0, 0, 0);
        repeat (3) @(posedge clk_i);
        #1;
        chk(fe, {32'h0, pf});
        chk(mv, {v2, 2'h0});
        caps(1, 1, 1, 1);
        wr(0, 32'hffff_ffff);
        chk({rd, le, se}, 34'h0);
        $display("refusal test done");
    endtask : t_off
    task give_verdict;
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : give_verdict
    // Hang guard: the tests need well under a hundred cycles
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 2000) begin
            miscompares++;
            give_verdict;
        end
    end
    initial begin
        repeat (4) @(posedge clk_i);
        rst_b_i <= 1'b1;
        #1;
        t_rst;
        t_on;
        t_off;
        give_verdict;
    end
endmodule : testbench
`default_nettype wire
